// File: inc/pss_pkg.sv
// pss_pkg: register map, field positions, encodings and reset values of the pin sampler.
// assumes: shared by the sampler core and its bench; no clock or reset of its own.
package pss_pkg;
	localparam int ADDR_W     = 8;
	localparam int PC_W       = 5;
	localparam int IMEM_WORDS = 32;
	localparam int INS_W      = 16;

	// register byte offsets
	localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
	localparam logic [ADDR_W-1:0] REG_CLKDIV   = 8'h04;
	localparam logic [ADDR_W-1:0] REG_PINCTRL  = 8'h08;
	localparam logic [ADDR_W-1:0] REG_SHIFT    = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_EXECCTRL = 8'h10;
	localparam logic [ADDR_W-1:0] REG_INJECT   = 8'h14;
	localparam logic [ADDR_W-1:0] REG_IMEM     = 8'h18;
	localparam logic [ADDR_W-1:0] REG_TXF      = 8'h1C;
	localparam logic [ADDR_W-1:0] REG_RXF      = 8'h20;
	localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h24;

	// field positions
	localparam int CTRL_EN         = 0;
	localparam int CTRL_RESTART    = 1;
	localparam int CTRL_FLUSH      = 2;
	localparam int CTRL_JOIN_LSB   = 3;
	localparam int DIV_INT_LSB     = 16;
	localparam int DIV_FRAC_LSB    = 8;
	localparam int PIN_IN_LSB      = 0;
	localparam int PIN_OUT_LSB     = 5;
	localparam int PIN_OUTCNT_LSB  = 10;
	localparam int PIN_SET_LSB     = 16;
	localparam int PIN_SETCNT_LSB  = 21;
	localparam int PIN_SIDE_LSB    = 24;
	localparam int PIN_SIDECNT_LSB = 29;
	localparam int SH_IN_RIGHT     = 0;
	localparam int SH_AUTOPUSH     = 1;
	localparam int SH_THR_LSB      = 2;
	localparam int SH_OUT_RIGHT    = 7;
	localparam int WRAP_BOT_LSB    = 0;
	localparam int WRAP_TOP_LSB    = 5;
	localparam int IMEM_ADDR_LSB   = 16;
	localparam int ST_RX_LSB       = 0;
	localparam int ST_TX_LSB       = 4;
	localparam int ST_PC_LSB       = 8;
	localparam int ST_STALL        = 16;
	localparam int ST_INJ          = 17;
	localparam int INS_OP_LSB      = 13;
	localparam int INS_SIDE_LSB    = 8;
	localparam int INS_ARG_LSB     = 5;
	localparam int INS_FLAG        = 7;

	// reset values
	localparam logic [31:0] CLKDIV_RST   = 32'h0001_0000;
	localparam logic [31:0] PINCTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] SHIFT_RST    = 32'h0000_0081;
	localparam logic [31:0] EXECCTRL_RST = 32'h0000_03E0;
	localparam logic [31:0] WORD_ONES    = 32'hFFFF_FFFF;
	localparam logic [5:0]  WORD_BITS    = 6'h20;

	// operand locations
	localparam logic [2:0] LOC_PINS    = 3'h0;
	localparam logic [2:0] LOC_X       = 3'h1;
	localparam logic [2:0] LOC_Y       = 3'h2;
	localparam logic [2:0] LOC_PINDIRS = 3'h4;
	localparam logic [2:0] LOC_IN_SHIFT  = 3'h6;
	localparam logic [2:0] LOC_OUT_SHIFT = 3'h7;

	typedef enum logic [2:0] {
		OP_JMP, OP_WAIT, OP_IN, OP_OUT, OP_PUSHPULL, OP_MOV, OP_NOP, OP_SET
	} pss_op_t;

	typedef enum logic [1:0] {JOIN_NONE, JOIN_TX, JOIN_RX} pss_join_t;
endpackage

// File: src/pss_sampler.sv
// pss_sampler: one programmable pin state machine with fifos, autopush and injection.
// assumes: one 250 MHz clock, avalon-mm master for registers, dma paced by the dreq flags.
`timescale 1ns/1ns
module pss_sampler #(
	parameter int FIFO_DEPTH = 4
) (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       resetn,
	// avalon-mm register slave
	input  wire logic [pss_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	input  wire logic [3:0]                 avs_byteenable,
	output logic      [31:0]                avs_readdata,
	output logic                            avs_waitrequest,
	// gpio
	input  wire logic [31:0]                pin_in,
	output logic      [31:0]                pin_out,
	output logic      [31:0]                pin_oe,
	// dma pacing
	output logic                            rx_dreq,
	output logic                            tx_dreq
);
	import pss_pkg::*;

	localparam int SLOTS = 2 * FIFO_DEPTH;
	localparam int PTR_W = $clog2(SLOTS);
	localparam int CNT_W = $clog2(SLOTS + 1);

	// write data into the bits of a pin group starting at base, wrapping at 32
	function automatic logic [31:0] pss_apply(input logic [31:0] cur, input logic [31:0] data,
		input logic [4:0] base, input logic [5:0] cnt);
		logic [31:0] r;
		logic [4:0]  off;
		r = cur;
		for (int i = 0; i < 32; i++) begin
			off = 5'(i) - base;
			if ({1'b0, off} < cnt)
				r[i] = data[off];
		end
		return r;
	endfunction

	// count field where zero means a full word
	function automatic logic [5:0] pss_count(input logic [4:0] f);
		return (f == 5'h00) ? WORD_BITS : {1'b0, f};
	endfunction

	// fifo capacity under the join setting
	function automatic logic [CNT_W-1:0] pss_cap(input pss_join_t j, input logic is_rx);
		if (j == (is_rx ? JOIN_RX : JOIN_TX))
			return CNT_W'(SLOTS);
		if (j == (is_rx ? JOIN_TX : JOIN_RX))
			return '0;
		return CNT_W'(FIFO_DEPTH);
	endfunction

	// byte-lane merge of a register write
	function automatic logic [31:0] pss_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (be[b])
				r[b*8 +: 8] = wd[b*8 +: 8];
		return r;
	endfunction

	logic              wait_r, en_r, inj_valid_r, stall_r, rx_dreq_r, tx_dreq_r, seen_r;
	pss_join_t         join_r;
	logic [31:0]       rdata_r, clkdiv_r, pinctrl_r, shift_r, execctrl_r;
	logic [31:0]       pin_meta_r, pin_sync_r, pout_r, poe_r, pout_nxt, poe_nxt;
	logic [31:0]       input_shift_reg_r, output_shift_reg_r, x_r, y_r, x_nxt, y_nxt;
	logic [31:0]       input_shift_reg_nxt, output_shift_reg_nxt;
	logic [31:0]       src_val, out_val, sh, push_data, pins_rot, status_w;
	logic [5:0]        icnt_r, icnt_nxt, n, thr;
	logic [INS_W-1:0]  inj_instr_r, instr;
	logic [INS_W-1:0]  imem [IMEM_WORDS];
	logic [PC_W-1:0]   pc_r, idx, wrap_bot, wrap_top;
	logic [15:0]       div_cnt_r, div_reload, since_r;
	logic [7:0]        facc_r;
	logic [8:0]        fsum;
	logic [2:0]        arg;
	pss_op_t           op;
	logic              acc, wr_acc, rd_acc, restart_p, flush_p, inj_wr, run, tick, exe;
	logic              stall, push_do, pull_do, jmp, rx_pop, tx_push, rx_full;
	logic [31:0]       rx_mem [SLOTS];
	logic [31:0]       tx_mem [SLOTS];
	logic [PTR_W-1:0]  rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
	logic [CNT_W-1:0]  rx_cnt_r, tx_cnt_r, rx_cnt_nxt, tx_cnt_nxt, rx_cap, tx_cap;

	// bus decode: each request is taken once, in the cycle waitrequest is high
	assign acc       = (avs_read | avs_write) & wait_r;
	assign wr_acc    = acc & avs_write;
	assign rd_acc    = acc & avs_read;
	assign restart_p = wr_acc & (avs_address == REG_CTRL) & avs_byteenable[0]
		& avs_writedata[CTRL_RESTART];
	assign flush_p   = wr_acc & (avs_address == REG_CTRL) & avs_byteenable[0]
		& avs_writedata[CTRL_FLUSH];
	assign inj_wr    = wr_acc & (avs_address == REG_INJECT);
	assign tx_push   = wr_acc & (avs_address == REG_TXF) & (tx_cnt_r < tx_cap);
	assign rx_pop    = rd_acc & (avs_address == REG_RXF) & (rx_cnt_r != '0);
	assign rx_cap    = pss_cap(join_r, 1'b1);
	assign tx_cap    = pss_cap(join_r, 1'b0);
	assign rx_full   = rx_cnt_r >= rx_cap;

	// outputs straight from flops
	assign avs_waitrequest = wait_r;
	assign avs_readdata    = rdata_r;
	assign pin_out         = pout_r;
	assign pin_oe          = poe_r;
	assign rx_dreq         = rx_dreq_r;
	assign tx_dreq         = tx_dreq_r;

	// waitrequest drops for one cycle after each taken request
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			wait_r <= 1'b1;
		else
			wait_r <= ~acc;
	end

	// configuration registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			en_r       <= 1'b0;
			join_r     <= JOIN_NONE;
			clkdiv_r   <= CLKDIV_RST;
			pinctrl_r  <= PINCTRL_RST;
			shift_r    <= SHIFT_RST;
			execctrl_r <= EXECCTRL_RST;
		end else if (wr_acc) begin
			if (avs_address == REG_CTRL && avs_byteenable[0]) begin
				en_r   <= avs_writedata[CTRL_EN];
				join_r <= pss_join_t'(avs_writedata[CTRL_JOIN_LSB +: 2]);
			end
			if (avs_address == REG_CLKDIV)
				clkdiv_r <= pss_merge(clkdiv_r, avs_writedata, avs_byteenable);
			if (avs_address == REG_PINCTRL)
				pinctrl_r <= pss_merge(pinctrl_r, avs_writedata, avs_byteenable);
			if (avs_address == REG_SHIFT)
				shift_r <= pss_merge(shift_r, avs_writedata, avs_byteenable);
			if (avs_address == REG_EXECCTRL)
				execctrl_r <= pss_merge(execctrl_r, avs_writedata, avs_byteenable);
		end
	end

	// program memory, written through a window register
	always_ff @(posedge clk) begin
		if (wr_acc && avs_address == REG_IMEM)
			imem[avs_writedata[IMEM_ADDR_LSB +: PC_W]] <= avs_writedata[INS_W-1:0];
	end

	// status word
	always_comb begin
		status_w                       = '0;
		status_w[ST_RX_LSB +: CNT_W]   = rx_cnt_r;
		status_w[ST_TX_LSB +: CNT_W]   = tx_cnt_r;
		status_w[ST_PC_LSB +: PC_W]    = pc_r;
		status_w[ST_STALL]             = stall_r;
		status_w[ST_INJ]               = inj_valid_r;
	end

	// read data, unmapped offsets read zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rdata_r <= '0;
		else if (rd_acc) begin
			case (avs_address)
				REG_CTRL:     rdata_r <= 32'({join_r, 2'b00, en_r});
				REG_CLKDIV:   rdata_r <= clkdiv_r;
				REG_PINCTRL:  rdata_r <= pinctrl_r;
				REG_SHIFT:    rdata_r <= shift_r;
				REG_EXECCTRL: rdata_r <= execctrl_r;
				REG_RXF:      rdata_r <= rx_pop ? rx_mem[rx_rp_r] : '0;
				REG_STATUS:   rdata_r <= status_w;
				default:      rdata_r <= '0;
			endcase
		end
	end

	// two-flop synchroniser on the pins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= pin_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	// fractional clock divider
	assign run        = en_r | inj_valid_r;
	assign tick       = div_cnt_r == 16'h0000;
	assign exe        = tick & run;
	assign fsum       = {1'b0, facc_r} + {1'b0, clkdiv_r[DIV_FRAC_LSB +: 8]};
	assign div_reload = ((clkdiv_r[DIV_INT_LSB +: 16] > 16'h0001) ?
		clkdiv_r[DIV_INT_LSB +: 16] - 16'h0001 : 16'h0000) + {15'h0000, fsum[8]};
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_cnt_r <= '0;
			facc_r    <= '0;
		end else if (restart_p || !run) begin
			div_cnt_r <= '0;
			facc_r    <= '0;
		end else if (tick) begin
			div_cnt_r <= div_reload;
			facc_r    <= fsum[7:0];
		end else
			div_cnt_r <= div_cnt_r - 16'h0001;
	end

	// instruction decode; injected word overrides program memory
	assign instr    = inj_valid_r ? inj_instr_r : imem[pc_r];
	assign op       = pss_op_t'(instr[INS_OP_LSB +: 3]);
	assign arg      = instr[INS_ARG_LSB +: 3];
	assign idx      = instr[0 +: PC_W];
	assign n        = pss_count(idx);
	assign thr      = pss_count(shift_r[SH_THR_LSB +: 5]);
	assign wrap_bot = execctrl_r[WRAP_BOT_LSB +: PC_W];
	assign wrap_top = execctrl_r[WRAP_TOP_LSB +: PC_W];
	// input group rotated so its base pin lands in bit 0
	assign pins_rot = (pin_sync_r >> pinctrl_r[PIN_IN_LSB +: 5])
		| (pin_sync_r << (WORD_BITS - {1'b0, pinctrl_r[PIN_IN_LSB +: 5]}));

	// operand source; a move names its source in the low bits, the others in arg
	always_comb begin
		case ((op == OP_MOV) ? instr[2:0] : arg)
			LOC_PINS: src_val = pins_rot;
			LOC_X:    src_val = x_r;
			LOC_Y:    src_val = y_r;
			LOC_IN_SHIFT:  src_val = input_shift_reg_r;
			LOC_OUT_SHIFT: src_val = output_shift_reg_r;
			default:  src_val = '0;
		endcase
	end

	// execute one instruction per divided tick
	always_comb begin
		logic [63:0] wide;
		logic [6:0]  sum;
		wide      = '0;
		sum       = {1'b0, icnt_r} + {1'b0, n};
		sh        = '0;
		out_val   = '0;
		input_shift_reg_nxt  = input_shift_reg_r;
		icnt_nxt  = icnt_r;
		output_shift_reg_nxt = output_shift_reg_r;
		x_nxt     = x_r;
		y_nxt     = y_r;
		pout_nxt  = pout_r;
		poe_nxt   = poe_r;
		push_do   = 1'b0;
		push_data = input_shift_reg_r;
		pull_do   = 1'b0;
		stall     = 1'b0;
		jmp       = 1'b0;
		if (exe) begin
			unique case (op)
				OP_JMP: jmp = 1'b1;
				OP_WAIT: stall = pin_sync_r[idx] != instr[INS_FLAG];
				OP_IN: begin
					if (shift_r[SH_IN_RIGHT]) begin
						wide = {src_val, input_shift_reg_r} >> n;
						sh   = wide[31:0];
					end else begin
						wide = {input_shift_reg_r, src_val << (WORD_BITS - n)} << n;
						sh   = wide[63:32];
					end
					if (shift_r[SH_AUTOPUSH] && sum >= {1'b0, thr}) begin
						if (rx_full)
							stall = 1'b1;
						else begin
							push_do   = 1'b1;
							push_data = sh;
							input_shift_reg_nxt = '0;
							icnt_nxt  = '0;
						end
					end else begin
						input_shift_reg_nxt = sh;
						icnt_nxt = (sum > {1'b0, WORD_BITS}) ? WORD_BITS : sum[5:0];
					end
				end
				OP_OUT: begin
					if (shift_r[SH_OUT_RIGHT]) begin
						out_val = output_shift_reg_r & ~(WORD_ONES << n);
						output_shift_reg_nxt = output_shift_reg_r >> n;
					end else begin
						wide    = {32'h0000_0000, output_shift_reg_r} << n;
						out_val = wide[63:32];
						output_shift_reg_nxt = output_shift_reg_r << n;
					end
					case (arg)
						LOC_PINS: pout_nxt = pss_apply(pout_r, out_val,
							pinctrl_r[PIN_OUT_LSB +: 5], pinctrl_r[PIN_OUTCNT_LSB +: 6]);
						LOC_PINDIRS: poe_nxt = pss_apply(poe_r, out_val,
							pinctrl_r[PIN_OUT_LSB +: 5], pinctrl_r[PIN_OUTCNT_LSB +: 6]);
						LOC_X: x_nxt = out_val;
						LOC_Y: y_nxt = out_val;
						LOC_IN_SHIFT: begin
							input_shift_reg_nxt = out_val;
							icnt_nxt = n;
						end
						default: ;
					endcase
				end
				OP_PUSHPULL: begin
					if (instr[INS_FLAG]) begin
						if (tx_cnt_r == '0)
							stall = 1'b1;
						else begin
							pull_do = 1'b1;
							output_shift_reg_nxt = tx_mem[tx_rp_r];
						end
					end else if (rx_full)
						stall = 1'b1;
					else begin
						push_do  = 1'b1;
						input_shift_reg_nxt = '0;
						icnt_nxt = '0;
					end
				end
				OP_MOV: begin
					case (instr[INS_FLAG -: 3])
						LOC_PINS: pout_nxt = pss_apply(pout_r, src_val,
							pinctrl_r[PIN_OUT_LSB +: 5], pinctrl_r[PIN_OUTCNT_LSB +: 6]);
						LOC_X: x_nxt = src_val;
						LOC_Y: y_nxt = src_val;
						LOC_IN_SHIFT: begin
							input_shift_reg_nxt = src_val;
							icnt_nxt = '0;
						end
						LOC_OUT_SHIFT: output_shift_reg_nxt = src_val;
						default: ;
					endcase
				end
				OP_NOP: ;
				OP_SET: begin
					case (arg)
						LOC_PINS: pout_nxt = pss_apply(pout_r, {27'h000_0000, idx},
							pinctrl_r[PIN_SET_LSB +: 5], {3'h0, pinctrl_r[PIN_SETCNT_LSB +: 3]});
						LOC_PINDIRS: poe_nxt = pss_apply(poe_r, {27'h000_0000, idx},
							pinctrl_r[PIN_SET_LSB +: 5], {3'h0, pinctrl_r[PIN_SETCNT_LSB +: 3]});
						LOC_X: x_nxt = {27'h000_0000, idx};
						LOC_Y: y_nxt = {27'h000_0000, idx};
						default: ;
					endcase
				end
			endcase
			// side-set lands with the instruction, stalled or not
			pout_nxt = pss_apply(pout_nxt, {27'h000_0000, instr[INS_SIDE_LSB +: 5]},
				pinctrl_r[PIN_SIDE_LSB +: 5], {3'h0, pinctrl_r[PIN_SIDECNT_LSB +: 3]});
		end
	end

	// machine datapath state; all pins of a group change on one edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			input_shift_reg_r  <= '0;
			icnt_r  <= '0;
			output_shift_reg_r <= '0;
			x_r     <= '0;
			y_r     <= '0;
			pout_r  <= '0;
			poe_r   <= '0;
			stall_r <= 1'b0;
		end else if (restart_p) begin
			input_shift_reg_r <= '0;
			icnt_r  <= '0;
			stall_r <= 1'b0;
		end else if (exe) begin
			input_shift_reg_r  <= input_shift_reg_nxt;
			icnt_r  <= icnt_nxt;
			output_shift_reg_r <= output_shift_reg_nxt;
			x_r     <= x_nxt;
			y_r     <= y_nxt;
			pout_r  <= pout_nxt;
			poe_r   <= poe_nxt;
			stall_r <= stall;
		end
	end

	// program counter: stall holds it, wrap loops it, injection leaves it unless the injected word is a jump
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			pc_r <= '0;
		else if (exe && !stall) begin
			if (jmp)
				pc_r <= idx;
			else if (!inj_valid_r)
				pc_r <= (pc_r == wrap_top) ? wrap_bot : pc_r + 1'b1;
		end
	end

	// injected instruction latch; a new write wins over completion
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			inj_valid_r <= 1'b0;
			inj_instr_r <= '0;
		end else if (inj_wr) begin
			inj_valid_r <= 1'b1;
			inj_instr_r <= avs_writedata[INS_W-1:0];
		end else if (exe && !stall)
			inj_valid_r <= 1'b0;
	end

	// fifo level bookkeeping
	always_comb begin
		rx_cnt_nxt = flush_p ? '0 : rx_cnt_r + CNT_W'(push_do) - CNT_W'(rx_pop);
		tx_cnt_nxt = flush_p ? '0 : tx_cnt_r + CNT_W'(tx_push) - CNT_W'(pull_do);
	end

	// fifo storage: one push and one pop per clock each way
	always_ff @(posedge clk) begin
		if (push_do)
			rx_mem[rx_wp_r] <= push_data;
		if (tx_push)
			tx_mem[tx_wp_r] <= avs_writedata;
	end

	// fifo pointers, flush and dma requests
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_wp_r   <= '0;
			rx_rp_r   <= '0;
			tx_wp_r   <= '0;
			tx_rp_r   <= '0;
			rx_cnt_r  <= '0;
			tx_cnt_r  <= '0;
			rx_dreq_r <= 1'b0;
			tx_dreq_r <= 1'b0;
		end else begin
			if (flush_p) begin
				rx_wp_r <= '0;
				rx_rp_r <= '0;
				tx_wp_r <= '0;
				tx_rp_r <= '0;
			end else begin
				rx_wp_r <= rx_wp_r + PTR_W'(push_do);
				rx_rp_r <= rx_rp_r + PTR_W'(rx_pop);
				tx_wp_r <= tx_wp_r + PTR_W'(tx_push);
				tx_rp_r <= tx_rp_r + PTR_W'(pull_do);
			end
			rx_cnt_r  <= rx_cnt_nxt;
			tx_cnt_r  <= tx_cnt_nxt;
			rx_dreq_r <= rx_cnt_nxt != '0;
			tx_dreq_r <= tx_cnt_nxt < tx_cap;
		end
	end

	// checking helpers: cycles between divided ticks
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			since_r <= '0;
			seen_r  <= 1'b0;
		end else begin
			since_r <= exe ? 16'h0000 : since_r + 16'h0001;
			seen_r  <= run & ~restart_p & ~(wr_acc & (avs_address == REG_CLKDIV)) & (seen_r | exe);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	a_div_spacing: assert property (exe && seen_r && clkdiv_r[DIV_FRAC_LSB +: 8] == 8'h00
		|-> since_r + 16'h0001 == ((clkdiv_r[DIV_INT_LSB +: 16] > 16'h0001) ?
		clkdiv_r[DIV_INT_LSB +: 16] : 16'h0001)) else $error("divided tick spacing wrong");
	a_autopush_clears: assert property (push_do && op == OP_IN && !restart_p
		|=> icnt_r == '0 && input_shift_reg_r == '0 && rx_cnt_r != '0)
		else $error("autopush left input shift register");
	a_full_stalls: assert property (exe && op == OP_IN && rx_full && shift_r[SH_AUTOPUSH]
		&& {1'b0, icnt_r} + {1'b0, n} >= {1'b0, thr} |-> stall && !push_do)
		else $error("push into full rx fifo");
	a_stall_holds_pc: assert property (exe && stall && !inj_valid_r
		|=> $stable(pc_r)) else $error("pc moved on stall");
	a_inject_latched: assert property (exe && stall && inj_valid_r && !inj_wr
		|=> inj_valid_r && $stable(inj_instr_r)) else $error("stalled injection lost");
	a_wait_release: assert property (exe && op == OP_WAIT && !stall && inj_valid_r && !inj_wr
		|=> !inj_valid_r ##0 instr == imem[pc_r]) else $error("wait did not release");
	a_wrap_loop: assert property (exe && !stall && !inj_valid_r && op != OP_JMP
		&& pc_r == wrap_top |=> pc_r == $past(wrap_bot)) else $error("wrap target missed");
	a_restart_count: assert property (restart_p |=> icnt_r == '0) else $error("restart kept count");
	a_flush_empty: assert property (flush_p |=> rx_cnt_r == '0 && tx_cnt_r == '0
		&& !rx_dreq_r) else $error("flush left data");
	a_rx_dreq_level: assert property (rx_dreq_r == (rx_cnt_r != '0))
		else $error("rx dreq disagrees with level");
	a_bus_pulse: assert property (!wait_r |=> wait_r) else $error("waitrequest low too long");

	c_autopush: cover property (push_do && op == OP_IN);
	c_trigger: cover property (exe && stall && op == OP_WAIT ##[1:20] exe && !stall && op == OP_WAIT);
	c_full_stall: cover property (exe && stall && op == OP_IN);
	c_joined_full: cover property (join_r == JOIN_RX && rx_cnt_r == CNT_W'(SLOTS));
endmodule

// File: sim/pss_dma.sv
// pss_dma: dma channel that drains the rx fifo of the sampler into a small capture array.
// assumes: owns the register bus only while go is high and words remain.
`timescale 1ns/1ns
module pss_dma #(
	parameter int WORDS = 4,
	parameter int GAP   = 1
) (
	// clock and pacing
	input  wire logic        clk,
	input  wire logic        go,
	input  wire logic        rx_dreq,
	// avalon-mm master side
	input  wire logic        avs_waitrequest,
	input  wire logic [31:0] avs_readdata,
	output logic      [7:0]  avs_address,
	output logic             avs_read
);
	logic [31:0] cap [WORDS];
	int          got;
	// one read per request, always from the same rx address, counted in words
	initial begin
		avs_read = 1'b0;
		avs_address = pss_pkg::REG_RXF;
		got = 0;
		wait (go);
		while (got < WORDS) begin
			@(posedge clk);
			if (rx_dreq === 1'b1) begin
				avs_read <= 1'b1;
				do @(posedge clk); while (avs_waitrequest !== 1'b0);
				cap[got] = avs_readdata;
				got++;
				avs_read <= 1'b0;
				repeat (GAP) @(posedge clk); // slow answer, dreq settles
			end
		end
	end
endmodule

// File: sim/pio_sampling_state_machine_tb.sv
// pio_sampling_state_machine_tb: capture, autopush, joined fifo, trigger and dma drain.
// assumes: pss_sampler with default fifo depth, pss_dma as the draining channel.
`timescale 1ns/1ns
module pio_sampling_state_machine_tb;
	import pss_pkg::*;
	logic        clk, resetn, t_rd, t_wr, go;
	logic [7:0]  t_a, d_a;
	logic [31:0] t_d, rdata, pin_in, q, pin_out, pin_oe;
	logic        wreq, rx_dreq, tx_dreq, d_rd, busy;
	int          err_count, total_checks, cyc;
	assign busy = go && (i_dma.got < 4);
	pss_sampler i_dut (.clk(clk), .resetn(resetn), .avs_address(busy ? d_a : t_a),
		.avs_read(busy ? d_rd : t_rd), .avs_write(t_wr), .avs_writedata(t_d),
		.avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wreq),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .rx_dreq(rx_dreq),
		.tx_dreq(tx_dreq));
	pss_dma i_dma (.clk(clk), .go(go), .rx_dreq(rx_dreq), .avs_waitrequest(wreq),
		.avs_readdata(rdata), .avs_address(d_a), .avs_read(d_rd));
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one bus access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		t_a <= a;
		t_d <= d;
		t_wr <= wr;
		t_rd <= !wr;
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdata;
		t_wr <= 1'b0;
		t_rd <= 1'b0;
	endtask
	initial begin
		{t_rd, t_wr, go, resetn} = 4'h0;
		{t_a, t_d, pin_in, err_count, total_checks, cyc} = '0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		bus(0, REG_SHIFT, 0); chk(q, 32'h0000_0081);
		bus(0, 8'h3C, 0); chk(q, 32'h0000_0000);
		// capture four pins per instruction, push every eight bits
		bus(1, REG_IMEM, 32'h0000_4004);
		bus(1, REG_SHIFT, 32'h0000_00A3);
		bus(1, REG_EXECCTRL, 32'h0000_0000);
		pin_in <= 32'h0000_000A;
		bus(1, REG_CTRL, 32'h0000_0011);
		repeat (40) @(posedge clk);
		bus(0, REG_STATUS, 0); chk(q & 32'h0001_000F, 32'h0001_0008);
		bus(0, REG_RXF, 0); chk(q, 32'hAA00_0000);
		// stop, flush and restart, then arm the pin trigger
		bus(1, REG_CTRL, 32'h0000_0010);
		bus(1, REG_CTRL, 32'h0000_0016);
		bus(0, REG_STATUS, 0); chk(q & 32'h0000_000F, 32'h0000_0000);
		bus(1, REG_INJECT, 32'h0000_20A5);
		bus(1, REG_CTRL, 32'h0000_0011);
		repeat (20) @(posedge clk);
		chk({31'h0, rx_dreq}, 32'h0000_0000);
		bus(0, REG_STATUS, 0); chk(q & 32'h0003_0000, 32'h0003_0000);
		go <= 1'b1;
		// new pattern on pins 3:0 shows whether the restart dropped the partial word
		pin_in <= 32'h0000_0025;
		while (i_dma.got < 4) @(posedge clk);
		for (int i = 0; i < 4; i++) chk(i_dma.cap[i], 32'h5500_0000);
		// fifos apart, fill tx, then drive set, side-set and out groups by injection
		bus(1, REG_CTRL, 32'h0000_0000);
		bus(1, REG_PINCTRL, 32'h5088_1000);
		bus(0, REG_STATUS, 0);
		chk({31'h0, tx_dreq}, 32'h0000_0001);
		for (int i = 0; i < 4; i++) bus(1, REG_TXF, 32'h0000_0009 - i);
		chk({31'h0, tx_dreq}, 32'h0000_0000);
		bus(0, REG_STATUS, 0);
		chk(q & 32'h0000_00F0, 32'h0000_0040);
		bus(1, REG_INJECT, 32'h0000_E38F);
		bus(1, REG_INJECT, 32'h0000_E105);
		bus(0, REG_STATUS, 0);
		chk(pin_oe, 32'h0000_0F00);
		chk(pin_out, 32'h0001_0500);
		bus(1, REG_INJECT, 32'h0000_8080);
		bus(1, REG_INJECT, 32'h0000_6004);
		bus(0, REG_STATUS, 0);
		chk(pin_out, 32'h0000_0509);
		chk({31'h0, tx_dreq}, 32'h0000_0001);
		print_verdict();
	end
endmodule
